// ---- rtl/swm_consts.svh ----
/*
 * Timing constants and command codes for the single-wire identity bus master.
 * Assumes a 40 MHz system clock.
 */
`ifndef SWM_CONSTS_SVH
`define SWM_CONSTS_SVH

`define SWM_CLK_MHZ 40
// Times in microseconds as specified
`define SWM_RESET_LOW_US 480
`define SWM_RESET_HIGH_US 480
`define SWM_SLOT_US 70
`define SWM_ONE_LOW_US 6
// Write zero releases before slot end so the slot keeps a released tail
`define SWM_ZERO_LOW_US 65
`define SWM_ZERO_MIN_US 60
`define SWM_READ_LOW_US 2
`define SWM_READ_SAMPLE_US 12
`define SWM_RECOVERY_US 2
`define SWM_PRES_SAMPLE_US 70
// Cycle counts derived from the times
`define SWM_RESET_LOW_CYC (`SWM_RESET_LOW_US * `SWM_CLK_MHZ)
`define SWM_RESET_HIGH_CYC (`SWM_RESET_HIGH_US * `SWM_CLK_MHZ)
`define SWM_SLOT_CYC (`SWM_SLOT_US * `SWM_CLK_MHZ)
`define SWM_ONE_LOW_CYC (`SWM_ONE_LOW_US * `SWM_CLK_MHZ)
`define SWM_ZERO_LOW_CYC (`SWM_ZERO_LOW_US * `SWM_CLK_MHZ)
`define SWM_ZERO_MIN_CYC (`SWM_ZERO_MIN_US * `SWM_CLK_MHZ)
`define SWM_READ_LOW_CYC (`SWM_READ_LOW_US * `SWM_CLK_MHZ)
`define SWM_READ_SAMPLE_CYC (`SWM_READ_SAMPLE_US * `SWM_CLK_MHZ)
`define SWM_RECOVERY_CYC (`SWM_RECOVERY_US * `SWM_CLK_MHZ)
`define SWM_PRES_SAMPLE_CYC (`SWM_PRES_SAMPLE_US * `SWM_CLK_MHZ)
// Command codes
`define SWM_CMD_READ_ID 8'h33
`define SWM_CMD_SEARCH 8'hf0
`define SWM_CMD_SELECT 8'h55
`define SWM_CMD_ALL 8'hcc
// Identity check: reflected x^8+x^5+x^4+1
`define SWM_CRC_POLY_REFL 8'h8c
`define SWM_CRC_INIT 8'h00

`endif

// ---- rtl/swm_pkg.sv ----
/*
 * Types shared by the single-wire bus master.
 * Assumes the constants header for all figures.
 */
package swm_pkg;
    typedef enum logic [1:0] {
        SWM_OP_RESET,
        SWM_OP_WRITE,
        SWM_OP_READ
    } swm_op_e;
endpackage : swm_pkg

// ---- rtl/swm_crc8.sv ----
/*
 * Bitwise identity check accumulator, least significant bit first.
 * Assumes bits are offered one per enable, in arrival order.
 */
`timescale 1ns/1ps
`include "swm_consts.svh"
module swm_crc8 (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Control
    input wire logic clear_in,
    input wire logic bit_en_in,
    input wire logic bit_in,
    // Result
    output logic [7:0] crc_out
);
    logic [7:0] crc_r;
    logic [7:0] crc_nxt;
    logic fb;

    always_comb begin
        fb = crc_r[0] ^ bit_in;
        crc_nxt = crc_r;
        if (clear_in) begin
            crc_nxt = `SWM_CRC_INIT;
        end else if (bit_en_in) begin
            // Shift right with the reflected polynomial, LSB first
            crc_nxt = {1'b0, crc_r[7:1]} ^ (fb ? `SWM_CRC_POLY_REFL : 8'h00);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            crc_r <= `SWM_CRC_INIT;
        end else begin
            crc_r <= crc_nxt;
        end
    end

    assign crc_out = crc_r;
endmodule : swm_crc8

// ---- rtl/swm_master.sv ----
/*
 * Single-wire identity bus master: reset/presence, write and read slots,
 * and an identity check over received bits.
 * Assumes an external pull-up on the line and a user that issues one
 * operation at a time while READY_OUT is high.
 */
`timescale 1ns/1ps
`include "swm_consts.svh"
module swm_master
    import swm_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RSTN_IN,
    // Operation request
    input wire logic REQ_VALID_IN,
    input wire swm_op_e REQ_OP_IN,
    input wire logic REQ_BIT_IN,
    input wire logic CRC_CLEAR_IN,
    input wire logic CRC_ACC_IN,
    output logic READY_OUT,
    // Operation result
    output logic DONE_OUT,
    output logic RESULT_BIT_OUT,
    output logic PRESENCE_OUT,
    output logic [7:0] CRC_OUT,
    // Open-drain line
    input wire logic LINE_IN,
    output logic LINE_OUT,
    output logic LINE_OE_OUT
);
    localparam int unsigned CW = 15;
    localparam logic [CW-1:0] RST_LOW = CW'(`SWM_RESET_LOW_CYC);
    localparam logic [CW-1:0] RST_HIGH = CW'(`SWM_RESET_HIGH_CYC);
    localparam logic [CW-1:0] PRES_SMP = CW'(`SWM_PRES_SAMPLE_CYC);
    localparam logic [CW-1:0] SLOT = CW'(`SWM_SLOT_CYC);
    localparam logic [CW-1:0] ONE_LOW = CW'(`SWM_ONE_LOW_CYC);
    localparam logic [CW-1:0] RD_LOW = CW'(`SWM_READ_LOW_CYC);
    localparam logic [CW-1:0] RD_SMP = CW'(`SWM_READ_SAMPLE_CYC);
    localparam logic [CW-1:0] REC = CW'(`SWM_RECOVERY_CYC);
    localparam logic [CW-1:0] ZERO_LOW = CW'(`SWM_ZERO_LOW_CYC);
    localparam logic [CW-1:0] ZERO_MIN = CW'(`SWM_ZERO_MIN_CYC);

    // Refuse a reset-high count too wide for the counter, and figures outside the reset and slot limits
    if (`SWM_RESET_HIGH_CYC >= (1 << CW) || `SWM_RESET_LOW_US >= 960 ||
        `SWM_SLOT_US < 60 || `SWM_SLOT_US >= 120 || `SWM_ONE_LOW_US >= 15 ||
        `SWM_READ_SAMPLE_US >= 15 || `SWM_ZERO_LOW_US < `SWM_ZERO_MIN_US ||
        `SWM_ZERO_LOW_US >= `SWM_SLOT_US) begin : g_bad_timing
        $error("swm_master: timing constants out of range");
    end

    typedef enum logic [2:0] {
        SWM_IDLE, SWM_RST_LOW, SWM_RST_HIGH, SWM_SLOT_RUN, SWM_RECOVER
    } swm_state_e;

    swm_state_e state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic is_read_r, is_read_nxt;
    logic wbit_r, wbit_nxt;
    logic rbit_r, rbit_nxt;
    logic pres_r, pres_nxt;
    logic drive_r, drive_nxt;
    logic done_r, done_nxt;
    logic sync1_r, sync2_r;
    logic crc_bit_en;

    // Pin passes two flip-flops before any use
    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= LINE_IN;
            sync2_r <= sync1_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + CW'(1);
        is_read_nxt = is_read_r;
        wbit_nxt = wbit_r;
        rbit_nxt = rbit_r;
        pres_nxt = pres_r;
        drive_nxt = 1'b0;
        done_nxt = 1'b0;
        crc_bit_en = 1'b0;
        case (state_r)
            SWM_IDLE: begin
                cnt_nxt = '0;
                // Idle leaves the line released so a pause never resets slaves
                if (REQ_VALID_IN) begin
                    is_read_nxt = (REQ_OP_IN == SWM_OP_READ);
                    wbit_nxt = REQ_BIT_IN;
                    drive_nxt = 1'b1;
                    state_nxt = (REQ_OP_IN == SWM_OP_RESET) ? SWM_RST_LOW : SWM_SLOT_RUN;
                    if (REQ_OP_IN == SWM_OP_RESET) begin
                        pres_nxt = 1'b0;
                    end
                end
            end
            SWM_RST_LOW: begin
                drive_nxt = 1'b1;
                if (cnt_r == RST_LOW - CW'(1)) begin
                    drive_nxt = 1'b0;
                    cnt_nxt = '0;
                    state_nxt = SWM_RST_HIGH;
                end
            end
            SWM_RST_HIGH: begin
                // Presence sampled after the longest wait, inside the pulse
                if (cnt_r == PRES_SMP) begin
                    pres_nxt = !sync2_r;
                end
                if (cnt_r == RST_HIGH - CW'(1)) begin
                    done_nxt = 1'b1;
                    state_nxt = SWM_IDLE;
                end
            end
            SWM_SLOT_RUN: begin
                // Write one and read start release early; write zero releases before slot end
                if (is_read_r) begin
                    drive_nxt = (cnt_r < RD_LOW - CW'(1));
                end else if (wbit_r) begin
                    drive_nxt = (cnt_r < ONE_LOW - CW'(1));
                end else begin
                    drive_nxt = (cnt_r < ZERO_LOW - CW'(1));
                end
                if (is_read_r && cnt_r == RD_SMP) begin
                    rbit_nxt = sync2_r;
                    crc_bit_en = CRC_ACC_IN;
                end
                if (cnt_r == SLOT - CW'(1)) begin
                    drive_nxt = 1'b0;
                    cnt_nxt = '0;
                    state_nxt = SWM_RECOVER;
                end
            end
            SWM_RECOVER: begin
                if (cnt_r == REC - CW'(1)) begin
                    done_nxt = 1'b1;
                    state_nxt = SWM_IDLE;
                end
            end
            default: begin
                state_nxt = SWM_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            state_r <= SWM_IDLE;
            cnt_r <= '0;
            is_read_r <= 1'b0;
            wbit_r <= 1'b1;
            rbit_r <= 1'b0;
            pres_r <= 1'b0;
            drive_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            is_read_r <= is_read_nxt;
            wbit_r <= wbit_nxt;
            rbit_r <= rbit_nxt;
            pres_r <= pres_nxt;
            drive_r <= drive_nxt;
            done_r <= done_nxt;
        end
    end

    swm_crc8 u_crc (
        .clk_in(MCLK_IN),
        .rstn_in(RSTN_IN),
        .clear_in(CRC_CLEAR_IN),
        .bit_en_in(crc_bit_en),
        .bit_in(sync2_r),
        .crc_out(CRC_OUT)
    );

    // Open drain: only ever drive low
    assign LINE_OUT = 1'b0;
    assign LINE_OE_OUT = drive_r;
    assign READY_OUT = (state_r == SWM_IDLE);
    assign DONE_OUT = done_r;
    assign RESULT_BIT_OUT = rbit_r;
    assign PRESENCE_OUT = pres_r;

    property p_reset_low;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (state_r == SWM_IDLE && REQ_VALID_IN && REQ_OP_IN == SWM_OP_RESET)
            |=> LINE_OE_OUT [*8];
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("reset low too short");

    property p_slot_start;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (state_r == SWM_IDLE && REQ_VALID_IN) |=> LINE_OE_OUT;
    endproperty
    a_slot_start: assert property (p_slot_start) else $error("slot did not start low");

    property p_one_release;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (state_r == SWM_SLOT_RUN && !is_read_r && wbit_r && cnt_r == ONE_LOW)
            |-> !LINE_OE_OUT;
    endproperty
    a_one_release: assert property (p_one_release) else $error("write one held too long");

    property p_zero_hold;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (state_r == SWM_SLOT_RUN && !is_read_r && !wbit_r && cnt_r == ZERO_MIN)
            |-> LINE_OE_OUT;
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("write zero released early");

    property p_zero_release;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (state_r == SWM_SLOT_RUN && !is_read_r && !wbit_r && cnt_r == ZERO_LOW)
            |-> !LINE_OE_OUT;
    endproperty
    a_zero_release: assert property (p_zero_release) else $error("write zero fills slot");

    property p_read_release;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (state_r == SWM_SLOT_RUN && is_read_r && cnt_r == RD_LOW) |-> !LINE_OE_OUT;
    endproperty
    a_read_release: assert property (p_read_release) else $error("read start too long");

    property p_slot_end;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (state_r == SWM_SLOT_RUN && cnt_r == SLOT - CW'(1))
            |=> state_r == SWM_RECOVER && !LINE_OE_OUT;
    endproperty
    a_slot_end: assert property (p_slot_end) else $error("slot length wrong");

    property p_low_only;
        @(posedge MCLK_IN) disable iff (!RSTN_IN) LINE_OUT == 1'b0;
    endproperty
    a_low_only: assert property (p_low_only) else $error("line driven high");

    property p_rst_high_quiet;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        state_r == SWM_RST_HIGH |-> !LINE_OE_OUT && !READY_OUT;
    endproperty
    a_rst_high_quiet: assert property (p_rst_high_quiet) else $error("reset recovery cut");
endmodule : swm_master

// ---- verif/swm_slave_model.sv ----
/* Behavioural identity slave for the single-wire master bench.
   Assumes the bench resolves the pulled-up line and feeds it back here. */
`timescale 1ns/1ps
module swm_slave_model #(
    parameter logic [7:0] FAMILY = 8'ha6, // Arbitrary value
    parameter logic [47:0] SERIAL = 48'h3c5a_9e01_27d4
) (
    // Line
    input wire logic line_in,
    output logic drv_out,
    // Last command seen
    output logic [7:0] cmd_out
);
    logic [63:0] rom;
    realtime t_fall = 0;
    event rst_end;

    function automatic logic [7:0] crc56(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        return c;
    endfunction : crc56

    task automatic wslot(output logic b);
        @(negedge line_in);
        #30000 b = line_in;
    endtask : wslot

    task automatic rslot(input logic b, output logic seen);
        @(negedge line_in);
        drv_out = !b;
        #13000 seen = line_in;
        #17000 drv_out = 1'b0;
    endtask : rslot

    task automatic session();
        logic [7:0] cmd;
        logic b;
        logic s;
        #30000 drv_out = 1'b1;
        #120000 drv_out = 1'b0;
        for (int i = 0; i < 8; i++) begin
            wslot(b);
            cmd[i] = b;
        end
        cmd_out = cmd;
        if (cmd == 8'h33 || cmd == 8'h0f) begin
            for (int i = 0; i < 64; i++) rslot(rom[i], s);
        end else if (cmd == 8'hf0) begin
            for (int i = 0; i < 64; i++) begin
                rslot(rom[i], s);
                rslot(!rom[i], s);
                wslot(b);
                if (b !== rom[i]) break;
            end
        end
        // Select and address-all fall through to silence
    endtask : session

    always @(negedge line_in) t_fall = $realtime;
    // Longer than any slot or presence pulse, so only a reset gets here
    always @(posedge line_in) begin
        if ($realtime - t_fall > 200000) -> rst_end;
    end

    initial begin
        rom = {crc56({SERIAL, FAMILY}), SERIAL, FAMILY};
        drv_out = 1'b0;
        cmd_out = 8'h00;
        @(rst_end);
        forever begin
            fork
                begin
                    session();
                    @(rst_end);
                end
                @(rst_end);
            join_any
            disable fork;
            drv_out = 1'b0;
        end
    end
endmodule : swm_slave_model

// ---- verif/testbench.sv ----
/* Bench for the single-wire master against a behavioural identity slave.
   Assumes the line is pulled up here and pulled low by either party. */
`timescale 1ns/1ps
module testbench;
    import swm_pkg::*;
    localparam logic [7:0] FAM = 8'ha6; // Arbitrary value
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    swm_op_e req_op = SWM_OP_RESET;
    logic req_bit = 1'b0;
    logic crc_clear = 1'b0;
    logic crc_acc = 1'b0;
    logic ready, done, result_bit, presence, line_out, oe, s_drv;
    logic [7:0] crc, s_cmd;
    wire line = !(oe === 1'b1 || s_drv === 1'b1);
    int err_total = 0;
    int num_checks = 0;
    realtime t_rise = 0;
    realtime t_rel = 0;

    always #12.5 mclk = ~mclk;
    always @(posedge oe) t_rise = $realtime;
    always @(negedge oe) t_rel = $realtime;

    swm_master u_dut (
        .MCLK_IN(mclk), .RSTN_IN(rstn), .REQ_VALID_IN(req_valid), .REQ_OP_IN(req_op),
        .REQ_BIT_IN(req_bit), .CRC_CLEAR_IN(crc_clear), .CRC_ACC_IN(crc_acc),
        .READY_OUT(ready), .DONE_OUT(done), .RESULT_BIT_OUT(result_bit),
        .PRESENCE_OUT(presence), .CRC_OUT(crc), .LINE_IN(line), .LINE_OUT(line_out),
        .LINE_OE_OUT(oe)
    );
    swm_slave_model #(.FAMILY(FAM)) u_dev (.line_in(line), .drv_out(s_drv), .cmd_out(s_cmd));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    function automatic logic [7:0] crc_of(input logic [7:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        return c;
    endfunction : crc_of

    // Issues one operation, waits for its end and judges the pulse it made
    task automatic do_op(input swm_op_e op, input logic b);
        realtime w;
        int n;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_op <= op;
        req_bit <= b;
        @(posedge mclk);
        req_valid <= 1'b0;
        @(negedge mclk);
        check(ready, 1'b0);
        n = 0;
        while (done !== 1'b1 && n < 40000) begin
            @(negedge mclk);
            n++;
        end
        check(n < 40000, 1'b1);
        w = t_rel - t_rise;
        if (op == SWM_OP_RESET) begin
            check(w >= 480000 && w < 960000, 1'b1);
            check($realtime - t_rel >= 480000, 1'b1);
        end else if (op == SWM_OP_WRITE && !b) begin
            check(w >= 60000 && w < 120000, 1'b1);
        end else begin
            check(w >= 1000 && w < 15000, 1'b1);
        end
        if (op != SWM_OP_RESET) begin
            check($realtime - t_rise >= 61000 && $realtime - t_rise < 121000, 1'b1);
        end
        check(ready, 1'b1);
        check(line, 1'b1);
    endtask : do_op

    task automatic sc_presence();
        check(oe, 1'b0);
        do_op(SWM_OP_RESET, 1'b0);
        check(presence, 1'b1);
    endtask : sc_presence

    task automatic sc_command();
        logic [7:0] c;
        c = 8'h33;
        for (int i = 0; i < 8; i++) do_op(SWM_OP_WRITE, c[i]);
        check(s_cmd, 8'h33);
    endtask : sc_command

    task automatic sc_read_family();
        logic [7:0] got;
        @(posedge mclk);
        crc_clear <= 1'b1;
        crc_acc <= 1'b1;
        @(posedge mclk);
        crc_clear <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            do_op(SWM_OP_READ, 1'b0);
            got[i] = result_bit;
        end
        check(got, FAM);
        check(crc, crc_of(FAM));
    endtask : sc_read_family

    // Master may only ever pull low
    always @(negedge mclk) begin
        if (rstn) check(line_out, 1'b0);
    end

    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        sc_presence();
        sc_command();
        sc_read_family();
        give_verdict();
    end

    // About 85k cycles are expected; the limit near 96k keeps a hang inside the run budget
    initial begin
        #2400000;
        err_total++;
        give_verdict();
    end
endmodule : testbench
